// File: common/pss_map.svh
// constants for the pipelined sram bus logic: widths, timing counts, resets
`ifndef PSS_MAP_SVH
`define PSS_MAP_SVH

// ----------------------------------------------------------------------------
// clock and sleep timing
// ----------------------------------------------------------------------------
`define PSS_CLK_PERIOD_NS      40
// entry is a longest time: rounds down; recovery is a least time: rounds up
`define PSS_SLEEP_ENTRY_NS     (2 * `PSS_CLK_PERIOD_NS)
`define PSS_SLEEP_RECOVERY_NS  (2 * `PSS_CLK_PERIOD_NS)
`define PSS_SLEEP_ENTRY_CYC    (`PSS_SLEEP_ENTRY_NS / `PSS_CLK_PERIOD_NS)
`define PSS_SLEEP_RECOVERY_CYC \
  ((`PSS_SLEEP_RECOVERY_NS + `PSS_CLK_PERIOD_NS - 1) / `PSS_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// word layout and burst
// ----------------------------------------------------------------------------
`define PSS_LANES              4
`define PSS_LANE_DATA_W        8
`define PSS_LANE_PAR_POS       8
`define PSS_ADDR_W             4
`define PSS_BURST_LEN          4
`define PSS_BUF_DEPTH          2

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define PSS_RST_OE             1'b0
`define PSS_RST_BUF_READY      1'b1

`endif

// File: common/pss_pkg.sv
// types shared by the pipelined sram bus logic
package pss_pkg;

  typedef enum logic [1:0] {
    PSS_ACC_NONE,
    PSS_ACC_READ,
    PSS_ACC_WRITE
  } pss_acc_t;

  typedef enum logic {
    PSS_ORDER_LINEAR,
    PSS_ORDER_INTERLEAVED
  } pss_order_t;

  typedef enum logic {
    PSS_AWAKE,
    PSS_ASLEEP
  } pss_pwr_t;

endpackage

// File: hw/pss_buf.sv
// small valid/ready buffer, flip-flop storage
`timescale 1ns/10ps
`default_nettype none

module pss_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  import pss_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           rd;
    logic [PW-1:0]           wr;
    logic [CW-1:0]           cnt;
  } pss_buf_t;

  pss_buf_t s_r;
  pss_buf_t s_nxt;
  logic     push;
  logic     pop;

  assign in_ready  = (s_r.cnt != FULL);
  assign out_valid = (s_r.cnt != '0);
  assign out_data  = s_r.mem[s_r.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data;
      s_nxt.wr = (s_r.wr == LAST) ? '0 : s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == LAST) ? '0 : s_r.rd + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end else if (pop && !push) begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule // pss_buf
`default_nettype wire

// File: hw/pss_sram_core.sv
// synchronous bus logic of a pipelined late-write common-i/o burst sram
//
// Contract
// R1 - write starts: qualified, all selects, write low
// R2 - pins released the edge after write acceptance
// R3 - write data latched on second edge after
// R4 - next access captured during write data transfer
// R5 - only unmasked byte lanes are updated
// R6 - controller never drives while outputs active
// R7 - burst counter serves four beats; load when low
// R8 - advance high ignores selects, continues latched type
// R9 - controller drives correct lane masks each beat
// R10 - sleep keeps contents; two cycles entry/exit
// R11 - in-flight accesses dropped; asleep ignores inputs
// R12 - controller deselects before raising sleep
// R13 - selects inactive two cycles after sleep exit
// R14 - interleaved order: start xor beat count
// R15 - linear order: low bits increment, wrap
// R16 - burst read: drives data, or dummy
// R17 - read load with output disabled is dummy
// R18 - write load, all masks off: nothing written
// R19 - burst write, masks off: advance, no write
// R20 - qualify high: edge ignored, state held
// R21 - read data after edge following acceptance
// R22 - deselect releases pins one edge later
// R23 - output enable gates pins, masked on writes
// R24 - comes up deselected, pins released
// R25 - sleep pin synchronised before use
`include "pss_map.svh"
`timescale 1ns/10ps
`default_nettype none

module pss_sram_core #(
  parameter int ADDR_W = `PSS_ADDR_W,
  parameter int LANES  = `PSS_LANES,
  parameter int LANE_W = `PSS_LANE_DATA_W
) (
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clock_qualify_n,
  input  wire logic                     chip_select_1_n,
  input  wire logic                     chip_select_2,
  input  wire logic                     chip_select_3_n,
  input  wire logic                     write_enable_n,
  input  wire logic                     advance_not_load,
  input  wire logic [LANES-1:0]         byte_lane_mask_n,
  input  wire logic [ADDR_W-1:0]        address,
  input  wire logic                     output_enable_n,
  input  wire logic                     burst_order_sel,
  input  wire logic                     sleep_request,
  input  wire logic [LANES*LANE_W-1:0]  data_in,
  output logic      [LANES*LANE_W-1:0]  data_out,
  output logic                          data_oe,
  input  wire logic [LANES-1:0]         parity_in,
  output logic      [LANES-1:0]         parity_out,
  output logic                          parity_oe,
  output logic                          sleep_active,
  output logic                          write_buffer_ready
);
  import pss_pkg::*;

  // --------------------------------------------------------------------------
  // sizes and state
  // --------------------------------------------------------------------------
  localparam int DW    = LANES * LANE_W;
  localparam int SW    = LANE_W + 1;
  localparam int WW    = LANES * SW;
  localparam int DEPTH = 1 << ADDR_W;
  localparam int EW    = ADDR_W + LANES + WW;

  typedef struct packed {
    logic [DEPTH-1:0][WW-1:0] mem;
    pss_acc_t                 a_acc;
    logic [ADDR_W-1:0]        a_addr;
    logic [LANES-1:0]         a_mask_n;
    pss_acc_t                 b_acc;
    logic [ADDR_W-1:0]        b_addr;
    logic [LANES-1:0]         b_mask_n;
    pss_acc_t                 bst_acc;
    logic [ADDR_W-1:0]        bst_base;
    logic [1:0]               bst_cnt;
    logic                     rd_act;
    logic [DW-1:0]            dout;
    logic [LANES-1:0]         pout;
    logic                     doe;
    pss_pwr_t                 pwr;
    logic                     wbr;
  } pss_core_t;

  pss_core_t         s_r;
  pss_core_t         s_nxt;
  logic [1:0]        pin_sync;
  logic              asleep;
  pss_order_t        order;
  logic              stall;
  logic              selected;
  logic              cap;
  logic [WW-1:0]     cap_word;
  logic              buf_in_ready;
  logic              buf_out_valid;
  logic              buf_out_ready;
  logic [EW-1:0]     buf_out_data;
  logic [EW-1:0]     buf_in_data;
  logic [ADDR_W-1:0] head_addr;
  logic [LANES-1:0]  head_mask_n;
  logic [WW-1:0]     head_word;

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [WW-1:0] pack_word(input logic [DW-1:0] d,
                                              input logic [LANES-1:0] p);
    logic [WW-1:0] w;
    w = '0;
    for (int i = 0; i < LANES; i++) begin
      w[i*SW +: SW] = {p[i], d[i*LANE_W +: LANE_W]};
    end
    return w;
  endfunction

  // replace only the lanes whose mask is asserted low
  function automatic logic [WW-1:0] merge(input logic [WW-1:0] old_w,
                                          input logic [WW-1:0] new_w,
                                          input logic [LANES-1:0] m_n);
    logic [WW-1:0] w;
    w = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!m_n[i]) begin
        w[i*SW +: SW] = new_w[i*SW +: SW]; // R5
      end
    end
    return w;
  endfunction

  function automatic logic [ADDR_W-1:0] beat_addr(
      input logic [ADDR_W-1:0] base, input logic [1:0] cnt,
      input pss_order_t ord);
    logic [ADDR_W-1:0] a;
    a = base;
    if (ord == PSS_ORDER_INTERLEAVED) begin
      a[1:0] = base[1:0] ^ cnt; // R14
    end else begin
      a[1:0] = base[1:0] + cnt; // R15
    end
    return a;
  endfunction

  // --------------------------------------------------------------------------
  // pin synchronisers: sleep and burst order strap
  // --------------------------------------------------------------------------
  // the synchroniser depth is the two-cycle entry and exit time
  pss_sync #(
    .W      (2),
    .STAGES (`PSS_SLEEP_ENTRY_CYC)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     ({burst_order_sel, sleep_request}),
    .dout    (pin_sync)
  ); // R25 R10

  assign asleep = pin_sync[0];
  assign order  = pin_sync[1] ? PSS_ORDER_INTERLEAVED : PSS_ORDER_LINEAR;

  // --------------------------------------------------------------------------
  // write buffer between the data pins and the array
  // --------------------------------------------------------------------------
  // the array drains on live edges and while asleep, so an awake wait state really holds it;
  // one push per live edge and one pop per live edge keeps it from overflowing
  assign stall         = clock_qualify_n;
  assign selected      = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign cap_word      = pack_word(data_in, parity_in);
  assign cap           = !stall && !asleep && (s_r.b_acc == PSS_ACC_WRITE)
                         && !(&s_r.b_mask_n); // R3 R18 R19
  assign buf_in_data   = {s_r.b_addr, s_r.b_mask_n, cap_word};
  assign buf_out_ready = !stall || asleep;
  assign {head_addr, head_mask_n, head_word} = buf_out_data;

  pss_buf #(
    .W     (EW),
    .DEPTH (`PSS_BUF_DEPTH)
  ) u_wbuf (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (cap),
    .in_ready  (buf_in_ready),
    .in_data   (buf_in_data),
    .out_valid (buf_out_valid),
    .out_ready (buf_out_ready),
    .out_data  (buf_out_data)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    logic [WW-1:0] rd_w;
    rd_w  = '0;
    s_nxt = s_r;

    // the array takes the oldest buffered write
    if (buf_out_valid && buf_out_ready) begin
      s_nxt.mem[head_addr] = merge(s_r.mem[head_addr], head_word,
                                   head_mask_n); // R5
    end

    if (!stall) begin // R20
      // pipeline: access stage moves to the data stage
      s_nxt.b_acc    = s_r.a_acc; // R4
      s_nxt.b_addr   = s_r.a_addr;
      s_nxt.b_mask_n = s_r.a_mask_n;
      s_nxt.a_mask_n = byte_lane_mask_n;

      if (!advance_not_load) begin // R7
        s_nxt.bst_cnt  = 2'h0;
        s_nxt.bst_base = address;
        s_nxt.a_addr   = address;
        if (selected) begin
          // R1: write enable low selects a write, high a read
          s_nxt.a_acc = write_enable_n ? PSS_ACC_READ : PSS_ACC_WRITE;
        end else begin
          s_nxt.a_acc = PSS_ACC_NONE;
        end
        s_nxt.bst_acc = s_nxt.a_acc;
      end else begin
        // selects and write enable ignored on a continue beat
        s_nxt.bst_cnt = s_r.bst_cnt + 2'h1; // R8
        s_nxt.a_acc   = s_r.bst_acc;
        s_nxt.a_addr  = beat_addr(s_r.bst_base, s_nxt.bst_cnt, order);
      end

      // read word leaves the array one edge after acceptance, with any
      // write still in the buffer or on the pins folded in
      if (s_r.a_acc == PSS_ACC_READ) begin // R21 R16
        rd_w = s_r.mem[s_r.a_addr];
        if (buf_out_valid && head_addr == s_r.a_addr) begin
          rd_w = merge(rd_w, head_word, head_mask_n);
        end
        if (cap && s_r.b_addr == s_r.a_addr) begin
          rd_w = merge(rd_w, cap_word, s_r.b_mask_n);
        end
        for (int i = 0; i < LANES; i++) begin
          s_nxt.dout[i*LANE_W +: LANE_W] = rd_w[i*SW +: LANE_W];
          s_nxt.pout[i] = rd_w[i*SW + `PSS_LANE_PAR_POS];
        end
        s_nxt.rd_act = 1'b1;
      end else begin
        // write data phase or deselect releases the pins
        s_nxt.rd_act = 1'b0; // R2 R22 R23
      end
    end

    // sleep drops the accesses in the pipeline stages and ignores the bus; the write buffer still drains
    if (asleep) begin
      s_nxt.a_acc   = PSS_ACC_NONE; // R11
      s_nxt.b_acc   = PSS_ACC_NONE;
      s_nxt.bst_acc = PSS_ACC_NONE;
      s_nxt.rd_act  = 1'b0;
    end

    // output enable is sampled every edge, even in wait states; a dummy
    // read keeps the pins released
    s_nxt.doe = s_nxt.rd_act && !output_enable_n; // R16 R17 R23
    s_nxt.pwr = asleep ? PSS_ASLEEP : PSS_AWAKE; // R10
    s_nxt.wbr = buf_in_ready;
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // contents survive reset; control comes up deselected
      s_r.mem      <= s_r.mem;
      s_r.a_acc    <= PSS_ACC_NONE; // R24
      s_r.a_addr   <= '0;
      s_r.a_mask_n <= '1;
      s_r.b_acc    <= PSS_ACC_NONE;
      s_r.b_addr   <= '0;
      s_r.b_mask_n <= '1;
      s_r.bst_acc  <= PSS_ACC_NONE;
      s_r.bst_base <= '0;
      s_r.bst_cnt  <= 2'h0;
      s_r.rd_act   <= 1'b0;
      s_r.dout     <= '0;
      s_r.pout     <= '0;
      s_r.doe      <= `PSS_RST_OE; // R24
      s_r.pwr      <= PSS_AWAKE;
      s_r.wbr      <= `PSS_RST_BUF_READY;
    end else begin
      s_r <= s_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign data_out           = s_r.dout;
  assign parity_out         = s_r.pout;
  assign data_oe            = s_r.doe;
  assign parity_oe          = s_r.doe;
  assign sleep_active       = (s_r.pwr == PSS_ASLEEP);
  assign write_buffer_ready = s_r.wbr;

endmodule // pss_sram_core
`default_nettype wire

// File: hw/pss_sync.sv
// multi-stage level synchroniser for asynchronous pins
`timescale 1ns/10ps
`default_nettype none

module pss_sync #(
  parameter int W      = 1,
  parameter int STAGES = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  import pss_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0][W-1:0] sh;
  } pss_sync_t;

  pss_sync_t s_r;
  pss_sync_t s_nxt;

  // stage 0 feeds only stage 1
  always_comb begin
    s_nxt = s_r;
    s_nxt.sh = {s_r.sh[STAGES-2:0], din};
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.sh[STAGES-1];

endmodule // pss_sync
`default_nettype wire

// File: test/pss_ctl_model.sv
// behavioural memory controller driving the sram bus pins
`timescale 1ns/10ps
`default_nettype none

module pss_ctl_model (
  input  wire logic  ref_clk,
  output logic       clock_qualify_n,
  output logic       chip_select_1_n,
  output logic       chip_select_2,
  output logic       chip_select_3_n,
  output logic       write_enable_n,
  output logic       advance_not_load,
  output logic [3:0] byte_lane_mask_n,
  output logic [3:0] address,
  output logic       output_enable_n,
  output logic [31:0] data_in,
  output logic [3:0] parity_in
);
  // write data goes out on the second live beat after its load, so a
  // two-stage queue of pending words is kept
  logic [35:0] wd_pend = 36'h0;
  logic        wd_due  = 1'b0;
  logic [35:0] wd_next = 36'h0;
  logic        wd_soon = 1'b0;
  initial begin
    {clock_qualify_n, chip_select_1_n, chip_select_2} = 3'b010;
    {chip_select_3_n, write_enable_n, advance_not_load} = 3'b110;
    {byte_lane_mask_n, address, output_enable_n} = 9'h1E1;
    {parity_in, data_in} = 36'h0;
  end
  // a stall leaves the data lines alone, so a write waiting for its
  // data edge keeps seeing its word
  task automatic drive(input logic cq_n, adv, we_n, oe_n,
                       input logic [2:0] cs, input logic [3:0] m_n, a,
                       input logic [35:0] wd, input logic wr);
    @(posedge ref_clk);
    #1;
    clock_qualify_n = cq_n;
    {chip_select_1_n, chip_select_2, chip_select_3_n} = cs;
    write_enable_n = we_n;
    advance_not_load = adv;
    byte_lane_mask_n = m_n;
    address = a;
    output_enable_n = oe_n;
    if (!cq_n) begin
      // pins released: show the inverse so a stale value never matches
      if (wd_due) {parity_in, data_in} = wd_pend;
      else {parity_in, data_in} = ~{parity_in, data_in};
      wd_due = wd_soon;
      wd_pend = wd_next;
      wd_soon = wr;
      wd_next = wd;
    end
  endtask
endmodule // pss_ctl_model
`default_nettype wire

// File: test/pss_sram_monitor.sv
// port checker for the pipelined sram bus logic
`timescale 1ns/10ps
`default_nettype none

module pss_sram_monitor #(
  parameter int ADDR_W = 4,
  parameter int LANES  = 4,
  parameter int LANE_W = 8
) (
  input wire logic                    ref_clk,
  input wire logic                    rst_n,
  input wire logic                    clock_qualify_n,
  input wire logic                    chip_select_1_n,
  input wire logic                    chip_select_2,
  input wire logic                    chip_select_3_n,
  input wire logic                    write_enable_n,
  input wire logic                    advance_not_load,
  input wire logic [LANES-1:0]        byte_lane_mask_n,
  input wire logic [ADDR_W-1:0]       address,
  input wire logic                    output_enable_n,
  input wire logic                    burst_order_sel,
  input wire logic                    sleep_request,
  input wire logic [LANES*LANE_W-1:0] data_in,
  input wire logic [LANES*LANE_W-1:0] data_out,
  input wire logic                    data_oe,
  input wire logic [LANES-1:0]        parity_in,
  input wire logic [LANES-1:0]        parity_out,
  input wire logic                    parity_oe,
  input wire logic                    sleep_active,
  input wire logic                    write_buffer_ready
);
  import pss_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic live, sel, rd_ld, wr_ld, ds_ld;
  assign live  = !clock_qualify_n && !sleep_active;
  assign sel   = !chip_select_1_n && chip_select_2 && !chip_select_3_n;
  assign rd_ld = live && !advance_not_load && sel && write_enable_n;
  assign wr_ld = live && !advance_not_load && sel && !write_enable_n;
  assign ds_ld = live && !advance_not_load && !sel;
  property p_wr_off; wr_ld ##1 live |=> !data_oe; endproperty
  a_wr_off: assert property (p_wr_off) else $error("drive after write");
  property p_rd_on; rd_ld ##1 (live && !output_enable_n) |=> data_oe;
  endproperty
  a_rd_on: assert property (p_rd_on) else $error("read not driven");
  property p_rd_dummy; rd_ld ##1 (live && output_enable_n) |=> !data_oe;
  endproperty
  a_rd_dummy: assert property (p_rd_dummy) else $error("dummy drove");
  property p_desel; ds_ld ##1 live |=> !data_oe; endproperty
  a_desel: assert property (p_desel) else $error("deselect drove");
  property p_sleep_in; $rose(sleep_request) |-> ##[1:3] sleep_active;
  endproperty
  a_sleep_in: assert property (p_sleep_in) else $error("no sleep");
  property p_sleep_out; $fell(sleep_request) |-> ##[1:3] !sleep_active;
  endproperty
  a_sleep_out: assert property (p_sleep_out) else $error("no wake");
  property p_sleep_hiz; sleep_active && $past(sleep_active) |-> !data_oe;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("asleep drove");
  property p_stall; clock_qualify_n |=> $stable(data_out);
  endproperty
  a_stall: assert property (p_stall) else $error("stall moved data");
  property p_oe_pair; data_oe == parity_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("enables differ");
  property p_rst; $rose(rst_n) |-> !data_oe && !sleep_active; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  cover property (rd_ld ##1 live ##1 data_oe);
  cover property ((advance_not_load && live) [*3]);
  cover property ($rose(sleep_active));
endmodule // pss_sram_monitor

bind pss_sram_core pss_sram_monitor #(
  .ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)
) i_mon (
  .ref_clk, .rst_n, .clock_qualify_n, .chip_select_1_n, .chip_select_2,
  .chip_select_3_n, .write_enable_n, .advance_not_load, .byte_lane_mask_n,
  .address, .output_enable_n, .burst_order_sel, .sleep_request, .data_in,
  .data_out, .data_oe, .parity_in, .parity_out, .parity_oe, .sleep_active,
  .write_buffer_ready
);
`default_nettype wire

// File: test/tb_top.sv
// self-checking bench for the pipelined sram bus logic
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("unexpected %s: expected %h, seen %h", nm, exp, got); \
    end \
  end

module tb_top;
  import pss_pkg::*;
  typedef struct packed {
    logic        rd;
    logic [35:0] d;
  } pss_exp_t;
  logic ref_clk = 1'b0, rst_n = 1'b0;
  logic burst_order_sel = 1'b0, sleep_request = 1'b0;
  logic clock_qualify_n, chip_select_1_n, chip_select_2, chip_select_3_n;
  logic write_enable_n, advance_not_load, output_enable_n;
  logic [3:0] byte_lane_mask_n, address, parity_in, parity_out;
  logic [31:0] data_in, data_out;
  logic data_oe, parity_oe, sleep_active, write_buffer_ready;
  int fail_count = 0, n_tests = 0;
  logic [35:0] mem [16];
  pss_exp_t exp_q[$];
  pss_exp_t nxt, prev;
  pss_acc_t typ = PSS_ACC_NONE;
  pss_order_t order = PSS_ORDER_LINEAR;
  logic [3:0] base = 4'h0;
  logic [1:0] cnt = 2'h0;
  logic asleep = 1'b0, live, oen, got, have = 1'b0;

  pss_sram_core i_dut (
    .ref_clk, .rst_n, .clock_qualify_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .write_enable_n, .advance_not_load, .byte_lane_mask_n,
    .address, .output_enable_n, .burst_order_sel, .sleep_request, .data_in,
    .data_out, .data_oe, .parity_in, .parity_out, .parity_oe, .sleep_active,
    .write_buffer_ready
  );
  pss_ctl_model i_ctl (
    .ref_clk, .clock_qualify_n, .chip_select_1_n, .chip_select_2,
    .chip_select_3_n, .write_enable_n, .advance_not_load, .byte_lane_mask_n,
    .address, .output_enable_n, .data_in, .parity_in
  );

  initial begin
    forever #20 ref_clk = ~ref_clk;
  end

  function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] m_n);
    merge = o;
    for (int i = 0; i < 4; i++)
      if (!m_n[i]) begin
        merge[8*i+:8] = n[8*i+:8];
        merge[32+i] = n[32+i];
      end
  endfunction

  // one bus access, sometimes preceded by a wait state full of noise
  task automatic acc(input logic adv, we_n, oe_n, input logic [3:0] m_n, a);
    logic [3:0]  ea;
    logic [35:0] wd;
    logic [2:0]  cs;
    wd = {4'($urandom), 32'($urandom)};
    cs = 3'($urandom);
    if ($urandom_range(3) == 0)
      i_ctl.drive(1'b1, 1'($urandom), 1'($urandom), 1'($urandom), cs,
                  4'($urandom), 4'($urandom), wd, 1'b0);
    if (!adv) begin
      typ = we_n ? PSS_ACC_READ : PSS_ACC_WRITE;
      base = a;
      cnt = 2'h0;
      cs = 3'b010;
    end else begin
      cnt = cnt + 2'h1;
    end
    ea = {base[3:2], (order == PSS_ORDER_INTERLEAVED) ?
          base[1:0] ^ cnt : base[1:0] + cnt};
    if (typ == PSS_ACC_WRITE && !asleep)
      mem[ea] = merge(mem[ea], wd, m_n);
    i_ctl.drive(1'b0, adv, we_n, oe_n, cs, m_n, a, wd,
                typ == PSS_ACC_WRITE);
    // noted once on the pins, so it pairs with the edge that takes it
    exp_q.push_back('{typ == PSS_ACC_READ && !asleep, mem[ea]});
  endtask

  task automatic idle();
    logic [2:0] cs;
    cs = 3'($urandom);
    if (cs == 3'b010) cs = 3'b110;
    if (asleep) cs = 3'b101;
    typ = PSS_ACC_NONE;
    i_ctl.drive(1'b0, 1'b0, 1'($urandom), 1'($urandom), cs, 4'($urandom),
                4'($urandom), 36'h0, 1'b0);
    exp_q.push_back('{1'b0, 36'h0});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // each live edge shows the result of the access taken one live edge back
  always @(posedge ref_clk) begin
    live = rst_n && !clock_qualify_n;
    oen = output_enable_n;
    got = live && exp_q.size() > 0;
    if (got) nxt = exp_q.pop_front();
    #2;
    if (live && have) begin
      `CHK("data_oe", data_oe, prev.rd && !oen)
      `CHK("write_buffer_ready", write_buffer_ready, 1'b1)
      if (prev.rd && !oen)
        `CHK("read word", {parity_out, data_out}, prev.d)
    end
    if (live) begin
      have = got;
      prev = nxt;
    end
  end

  initial begin
    void'($urandom(32'h4196CB20));
    repeat (3) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int a = 0; a < 16; a++) acc(1'b0, 1'b0, 1'b0, 4'h0, 4'(a));
    for (int a = 0; a < 16; a++) acc(1'b0, 1'b1, 1'b0, 4'h0, 4'(a));
    for (int m = 0; m < 16; m++) begin
      acc(1'b0, 1'b0, 1'($urandom), 4'(m), 4'(m));
      acc(1'b0, 1'b1, 1'b0, 4'h0, 4'(m));
    end
    for (int o = 0; o < 2; o++) begin
      order = pss_order_t'(o);
      burst_order_sel = 1'(o);
      repeat (3) idle();
      for (int s = 0; s < 4; s++) begin
        for (int b = 0; b < 4; b++)
          acc(1'(b != 0), 1'(b != 0) & 1'($urandom), 1'b0,
              (b == s) ? 4'hF : 4'($urandom), 4'(5 * s));
        for (int b = 0; b < 5; b++)
          acc(1'(b != 0), 1'b1, 1'($urandom), 4'($urandom), 4'(5 * s));
        idle();
      end
    end
    sleep_request = 1'b1;
    repeat (3) idle();
    `CHK("sleep_active", sleep_active, 1'b1)
    asleep = 1'b1;
    acc(1'b0, 1'b0, 1'b0, 4'h0, 4'h3);
    idle();
    sleep_request = 1'b0;
    repeat (3) idle();
    asleep = 1'b0;
    `CHK("sleep_active", sleep_active, 1'b0)
    acc(1'b0, 1'b1, 1'b0, 4'h0, 4'h3);
    repeat (2) idle();
    give_verdict();
  end

  // well over the few hundred cycles the sequence needs
  initial begin
    repeat (5000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
